/* File: inc/mii_port_defines.vh */
`ifndef MII_PORT_DEFINES_VH
`define MII_PORT_DEFINES_VH
// core clock period in ns
`define CORE_PERIOD_NS      10
// mdc half period in ns, management clock at 2.5 MHz
`define MDC_HALF_NS         200
// mdc half period in core cycles, rounded down, at least one
`define MDC_HALF_CYC        ((`MDC_HALF_NS / `CORE_PERIOD_NS) < 1 ? 1 : (`MDC_HALF_NS / `CORE_PERIOD_NS))
// cycles after reset release at which the strap is caught
`define STRAP_DELAY_CYC     8'h10
// clause 22 field values
`define MGMT_START          2'h1
`define MGMT_OP_WRITE       2'h1
`define MGMT_OP_READ        2'h2
`define MGMT_TA_WRITE       2'h2
`define MGMT_PREAMBLE_BITS  6'h20
`define MGMT_FRAME_BITS     6'h20
// frame bit index where the turnaround begins
`define MGMT_TA_BIT         6'h0e
// idle values
`define NIBBLE_ZERO         4'h0
`endif

/* File: logic/nibble_fifo.v */
`timescale 1ns/1ps
// small synchronous fifo with valid/ready on both sides
module nibble_fifo #(
    parameter WIDTH = 4,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage words
    reg [AW-1:0]    wr_ptr_reg;      // write pointer
    reg [AW-1:0]    rd_ptr_reg;      // read pointer
    reg [AW:0]      count_reg;       // words held
    wire push;
    wire pop;
    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_reg];
    assign push = in_valid & in_ready;
    assign pop  = out_valid & out_ready;
    // pointer and count update
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                                 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                                 : rd_ptr_reg + 1'b1;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop & ~push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
    // storage write, no reset needed
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end
endmodule

/* File: logic/mii_port.v */
`timescale 1ns/1ps
`include "mii_port_defines.vh"
module mii_port #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW    = 3
) (
    input  wire        CORE_CLK,
    input  wire        RST,
    input  wire        INTERNAL_PHY_SEL,
    input  wire        MGMT_PORT_SELECT,
    input  wire [3:0]  TX_NIBBLE,
    input  wire        TX_NIBBLE_VALID,
    output reg         TX_NIBBLE_READY,
    output reg  [3:0]  RX_NIBBLE,
    output reg         RX_NIBBLE_VALID,
    output reg         RX_FRAME_ERR,
    output reg         COLLISION,
    output reg         CARRIER,
    input  wire        MII_TX_CLK,
    output reg  [3:0]  MII_TXD,
    output reg         MII_TX_EN,
    input  wire        MII_RX_CLK,
    input  wire [3:0]  MII_RXD,
    input  wire        MII_RX_DV,
    input  wire        MII_RX_ER,
    input  wire        MII_COL,
    input  wire        MII_CRS,
    output reg         MDC,
    input  wire        MDIO_IN,
    output reg         MDIO_OUT,
    output reg         MDIO_OE,
    output reg         OUTSIDE_PHY_STRAP,
    input  wire        MGMT_START_REQ,
    input  wire        MGMT_READ,
    input  wire [4:0]  MGMT_PHY_ADDR,
    input  wire [4:0]  MGMT_REG_ADDR,
    input  wire [15:0] MGMT_WDATA,
    output reg  [15:0] MGMT_RDATA,
    output reg         MGMT_BUSY,
    output reg         MGMT_DONE
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, single-bit change taken once stages two and three agree, rx data taken straight from stage three
    reg [2:0] txc_s_reg;    // tx clock sync
    reg [2:0] rxc_s_reg;    // rx clock sync
    reg [2:0] dv_s_reg;     // rx valid sync
    reg [2:0] er_s_reg;     // rx error sync
    reg [2:0] col_s_reg;    // collision sync
    reg [2:0] crs_s_reg;    // carrier sync
    reg [2:0] mdi_s_reg;    // mdio sync
    reg [3:0] rxd_a_reg;    // rx data stage one
    reg [3:0] rxd_b_reg;    // rx data stage two
    reg [3:0] rxd_c_reg;    // rx data stage three
    reg       txc_q_reg;    // filtered tx clock
    reg       rxc_q_reg;    // filtered rx clock
    reg       dv_q_reg;     // filtered rx valid
    reg       mdi_q_reg;    // filtered mdio

    // agreement filter
    function filt;
        input [2:0] s;
        input       q;
        begin
            filt = (s[1] == s[2]) ? s[2] : q;
        end
    endfunction

    // shift pins into sync chains
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            txc_s_reg <= 3'h0;
            rxc_s_reg <= 3'h0;
            dv_s_reg  <= 3'h0;
            er_s_reg  <= 3'h0;
            col_s_reg <= 3'h0;
            crs_s_reg <= 3'h0;
            mdi_s_reg <= 3'h0;
            rxd_a_reg <= `NIBBLE_ZERO;
            rxd_b_reg <= `NIBBLE_ZERO;
            rxd_c_reg <= `NIBBLE_ZERO;
            txc_q_reg <= 1'b0;
            rxc_q_reg <= 1'b0;
            dv_q_reg  <= 1'b0;
            mdi_q_reg <= 1'b0;
        end else begin
            txc_s_reg <= {txc_s_reg[1:0], MII_TX_CLK};
            rxc_s_reg <= {rxc_s_reg[1:0], MII_RX_CLK};
            dv_s_reg  <= {dv_s_reg[1:0], MII_RX_DV};
            er_s_reg  <= {er_s_reg[1:0], MII_RX_ER};
            col_s_reg <= {col_s_reg[1:0], MII_COL};
            crs_s_reg <= {crs_s_reg[1:0], MII_CRS};
            mdi_s_reg <= {mdi_s_reg[1:0], MDIO_IN};
            rxd_a_reg <= MII_RXD;
            rxd_b_reg <= rxd_a_reg;
            rxd_c_reg <= rxd_b_reg;
            txc_q_reg <= filt(txc_s_reg, txc_q_reg);
            rxc_q_reg <= filt(rxc_s_reg, rxc_q_reg);
            dv_q_reg  <= filt(dv_s_reg, dv_q_reg);
            mdi_q_reg <= filt(mdi_s_reg, mdi_q_reg);
        end
    end

    wire txc_rise = filt(txc_s_reg, txc_q_reg) & ~txc_q_reg; // tx clock rising
    wire rxc_rise = filt(rxc_s_reg, rxc_q_reg) & ~rxc_q_reg; // rx clock rising

    ////////////////////////////////////////////////////////////////////////////
    // transmit path through the fifo
    wire [3:0] fifo_data;   // head nibble
    wire       fifo_valid;  // head present
    wire       fifo_ready;  // room for source
    wire       fifo_pop;    // take on tx edge
    assign fifo_pop = txc_rise & ~INTERNAL_PHY_SEL;

    nibble_fifo #(
        .WIDTH (4),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_tx_fifo (
        .clk       (CORE_CLK),
        .rst       (RST),
        .in_data   (TX_NIBBLE),
        .in_valid  (TX_NIBBLE_VALID),
        .in_ready  (fifo_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // launch one nibble per phy tx clock, parked when internal phy selected
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            MII_TXD         <= `NIBBLE_ZERO;
            MII_TX_EN       <= 1'b0;
            TX_NIBBLE_READY <= 1'b0;
        end else begin
            TX_NIBBLE_READY <= fifo_ready;
            if (INTERNAL_PHY_SEL) begin
                MII_TXD   <= `NIBBLE_ZERO;
                MII_TX_EN <= 1'b0;
            end else if (txc_rise) begin
                MII_TXD   <= fifo_valid ? fifo_data : `NIBBLE_ZERO;
                MII_TX_EN <= fifo_valid;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive path: sample nibble on rx clock rise while valid
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            RX_NIBBLE       <= `NIBBLE_ZERO;
            RX_NIBBLE_VALID <= 1'b0;
            RX_FRAME_ERR    <= 1'b0;
            COLLISION       <= 1'b0;
            CARRIER         <= 1'b0;
        end else begin
            RX_NIBBLE_VALID <= rxc_rise & dv_q_reg;
            if (rxc_rise & dv_q_reg) begin
                RX_NIBBLE <= rxd_c_reg;
            end
            // error sticks for the frame, cleared when valid drops
            if (!dv_q_reg) begin
                RX_FRAME_ERR <= 1'b0;
            end else if (filt(er_s_reg, RX_FRAME_ERR)) begin
                RX_FRAME_ERR <= 1'b1;
            end
            COLLISION <= filt(col_s_reg, COLLISION);
            CARRIER   <= filt(crs_s_reg, CARRIER);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strap capture after reset release
    reg [7:0] strap_cnt_reg;  // release delay
    reg       strap_done_reg; // strap caught
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            strap_cnt_reg     <= 8'h00;
            strap_done_reg    <= 1'b0;
            OUTSIDE_PHY_STRAP <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_cnt_reg <= strap_cnt_reg + 8'h01;
            if (strap_cnt_reg == `STRAP_DELAY_CYC) begin
                OUTSIDE_PHY_STRAP <= mdi_q_reg;
                strap_done_reg    <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // management engine: mdc divider and clause 22 shifter
    localparam ST_IDLE = 2'h0; // waiting
    localparam ST_PRE  = 2'h1; // preamble
    localparam ST_BODY = 2'h2; // frame
    localparam ST_END  = 2'h3; // finish

    reg [1:0]  st_reg;        // state
    reg [7:0]  div_reg;       // mdc half period count
    reg [5:0]  bit_reg;       // bits left
    reg [31:0] shift_reg;     // outgoing frame
    reg        rd_reg;        // read in progress
    wire       half_tick = (div_reg == `MDC_HALF_CYC - 1);
    wire       mdc_fall  = half_tick & MDC;  // drive on falling mdc
    wire       mdc_rise  = half_tick & ~MDC; // sample on rising mdc

    // sequencing of a management frame
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            st_reg     <= ST_IDLE;
            div_reg    <= 8'h00;
            bit_reg    <= 6'h00;
            shift_reg  <= 32'h0000_0000;
            rd_reg     <= 1'b0;
            MDC        <= 1'b0;
            MDIO_OUT   <= 1'b0;
            MDIO_OE    <= 1'b0;
            MGMT_RDATA <= 16'h0000;
            MGMT_BUSY  <= 1'b0;
            MGMT_DONE  <= 1'b0;
        end else begin
            MGMT_DONE <= 1'b0;
            div_reg   <= half_tick ? 8'h00 : div_reg + 8'h01;
            if (!MGMT_PORT_SELECT) begin
                MDC       <= 1'b0;
                MDIO_OE   <= 1'b0;
                MDIO_OUT  <= 1'b0;
                st_reg    <= ST_IDLE;
                MGMT_BUSY <= 1'b0;
            end else begin
                if (half_tick && st_reg != ST_IDLE) begin
                    MDC <= ~MDC;
                end
                case (st_reg)
                    ST_IDLE: begin
                        MDC <= 1'b0;
                        if (MGMT_START_REQ) begin
                            // start, opcode, addresses, turnaround, data
                            shift_reg <= {`MGMT_START,
                                          MGMT_READ ? `MGMT_OP_READ : `MGMT_OP_WRITE,
                                          MGMT_PHY_ADDR, MGMT_REG_ADDR,
                                          `MGMT_TA_WRITE, MGMT_WDATA};
                            rd_reg    <= MGMT_READ;
                            bit_reg   <= `MGMT_PREAMBLE_BITS;
                            div_reg   <= 8'h00;
                            MGMT_BUSY <= 1'b1;
                            MDIO_OE   <= 1'b1;
                            MDIO_OUT  <= 1'b1;
                            st_reg    <= ST_PRE;
                        end
                    end
                    ST_PRE: begin
                        if (mdc_fall) begin
                            if (bit_reg == 6'h01) begin
                                bit_reg  <= `MGMT_FRAME_BITS;
                                MDIO_OUT <= shift_reg[31];
                                st_reg   <= ST_BODY;
                            end else begin
                                bit_reg <= bit_reg - 6'h01;
                            end
                        end
                    end
                    ST_BODY: begin
                        if (mdc_rise && rd_reg && bit_reg <= 6'h10) begin
                            MGMT_RDATA <= {MGMT_RDATA[14:0], mdi_q_reg};
                        end
                        if (mdc_fall) begin
                            shift_reg <= {shift_reg[30:0], 1'b0};
                            bit_reg   <= bit_reg - 6'h01;
                            MDIO_OUT  <= shift_reg[30];
                            if (rd_reg && bit_reg == `MGMT_TA_BIT + 6'h05) begin
                                MDIO_OE <= 1'b0;          // release for turnaround
                            end
                            if (bit_reg == 6'h01) begin
                                st_reg <= ST_END;
                            end
                        end
                    end
                    ST_END: begin
                        MDIO_OE   <= 1'b0;
                        MDIO_OUT  <= 1'b0;
                        MDC       <= 1'b0;
                        MGMT_BUSY <= 1'b0;
                        MGMT_DONE <= 1'b1;
                        st_reg    <= ST_IDLE;
                    end
                    default: begin
                        st_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

/* File: verif/mii_port_assertions.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// pin rules of the mii port, seen from its top ports only
module mii_port_assertions (
    input wire       CORE_CLK,
    input wire       RST,
    input wire       INTERNAL_PHY_SEL,
    input wire       MGMT_PORT_SELECT,
    input wire       MGMT_START_REQ,
    input wire [3:0] MII_TXD,
    input wire       MII_TX_EN,
    input wire [3:0] MII_RXD,
    input wire       MII_RX_DV,
    input wire       MII_RX_ER,
    input wire       MII_COL,
    input wire [3:0] RX_NIBBLE,
    input wire       RX_NIBBLE_VALID,
    input wire       RX_FRAME_ERR,
    input wire       COLLISION,
    input wire       MDC,
    input wire       MDIO_OE,
    input wire       MDIO_OUT,
    input wire       MGMT_BUSY,
    input wire       MGMT_DONE
);
    int unsigned park_cnt; // cycles with internal phy in use
    int unsigned busy_cnt; // cycles of the running frame
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////////
    // helper counters for parking time and frame length
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            park_cnt <= 0;
            busy_cnt <= 0;
        end else begin
            park_cnt <= INTERNAL_PHY_SEL ? (park_cnt < 99 ? park_cnt + 1 : park_cnt) : 0;
            busy_cnt <= MGMT_BUSY ? busy_cnt + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // management frame steps
    sequence s_start;
        MGMT_START_REQ && MGMT_PORT_SELECT && !MGMT_BUSY && !MGMT_DONE;
    endsequence
    sequence s_driving;
        MGMT_BUSY && MDIO_OE && MDIO_OUT;
    endsequence
    property p_park; park_cnt >= 20 |-> MII_TXD == 4'h0 && !MII_TX_EN; endproperty
    property p_mdc_low; !MGMT_PORT_SELECT && !$past(MGMT_PORT_SELECT) |-> !MDC; endproperty
    property p_hiz; !MGMT_PORT_SELECT && !$past(MGMT_PORT_SELECT) |-> !MDIO_OE; endproperty
    property p_mdc_half;
        disable iff (RST || !MGMT_PORT_SELECT) $changed(MDC) |=> $stable(MDC) [*8];
    endproperty
    property p_start; s_start |=> s_driving; endproperty
    property p_len; MGMT_DONE |-> busy_cnt >= 2540 && busy_cnt <= 2580; endproperty
    property p_rx_dv; RX_NIBBLE_VALID |-> $past(MII_RX_DV, 4); endproperty
    property p_rx_data; RX_NIBBLE_VALID |-> RX_NIBBLE == $past(MII_RXD, 4); endproperty
    property p_err; RX_NIBBLE_VALID && $past(MII_RX_ER, 4) |-> ##[0:2] RX_FRAME_ERR; endproperty
    property p_col; MII_COL [*8] |-> COLLISION; endproperty
    a_park: assert property (p_park) else $error("tx pins not parked");
    a_mdc_low: assert property (p_mdc_low) else $error("mdc not low");
    a_hiz: assert property (p_hiz) else $error("mdio driven");
    a_mdc_half: assert property (p_mdc_half) else $error("mdc too fast");
    a_start: assert property (p_start) else $error("frame not started");
    a_len: assert property (p_len) else $error("frame length wrong");
    a_rx_dv: assert property (p_rx_dv) else $error("nibble without valid");
    a_rx_data: assert property (p_rx_data) else $error("nibble bits wrong");
    a_err: assert property (p_err) else $error("frame error missed");
    a_col: assert property (p_col) else $error("collision missed");
endmodule
bind mii_port mii_port_assertions i_mii_port_assertions (.CORE_CLK, .RST, .INTERNAL_PHY_SEL,
    .MGMT_PORT_SELECT, .MGMT_START_REQ, .MII_TXD, .MII_TX_EN, .MII_RXD, .MII_RX_DV, .MII_RX_ER,
    .MII_COL, .RX_NIBBLE, .RX_NIBBLE_VALID, .RX_FRAME_ERR, .COLLISION, .MDC, .MDIO_OE,
    .MDIO_OUT, .MGMT_BUSY, .MGMT_DONE);

/* File: verif/phy_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// outside phy: free link clocks, rx frames, tx and mdio capture
module phy_model (
    output reg        tx_clk,
    output reg        rx_clk,
    input  wire [3:0] txd,
    input  wire       tx_en,
    output reg  [3:0] rxd,
    output reg        rx_dv,
    output reg        rx_er,
    input  wire       mdc,
    input  wire       mdio,
    output reg        mdio_drv,
    output reg        mdio_bit
);
    logic [3:0]  tx_seen[$]; // nibbles taken off the wire
    logic [63:0] mdio_shift; // last management bits
    int          rises;      // mdc rises since the bench cleared it
    logic [15:0] rd_word;    // register value returned on reads
    // link clocks, 125 ns period, unrelated phase
    initial begin
        tx_clk = 1'b0;
        rx_clk = 1'b0;
        rxd = 4'h0;
        rx_dv = 1'b0;
        rx_er = 1'b0;
        mdio_shift = 64'h0;
        rises = 0;
        rd_word = 16'h0000;
        mdio_drv = 1'b0;
        mdio_bit = 1'b0;
        #3.3;
        forever begin
            #62.5;
            tx_clk = ~tx_clk;
            rx_clk = ~rx_clk;
        end
    end
    // capture sent nibbles and management bits
    always @(posedge tx_clk) if (tx_en === 1'b1) tx_seen.push_back(txd);
    always @(posedge mdc) mdio_shift <= {mdio_shift[62:0], mdio};
    always @(posedge mdc) rises <= rises + 1;
    // turnaround zero then read data, msb first, changed on mdc fall
    always @(negedge mdc) begin
        mdio_drv <= rises >= 47 && rises <= 63;
        mdio_bit <= (rises >= 48 && rises <= 63) ? rd_word[63 - rises] : 1'b0;
    end
    // four-nibble frame, first nibble from the top
    task automatic send_frame(input logic [15:0] nibs, input logic [3:0] errs);
        int i;
        for (i = 3; i >= 0; i--) begin
            @(negedge rx_clk);
            rx_dv = 1'b1;
            rxd = nibs[i*4 +: 4];
            rx_er = errs[i];
        end
        @(negedge rx_clk);
        rx_dv = 1'b0;
        rx_er = 1'b0;
        rxd = 4'h0; // pull-down level once released
    endtask
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic        CORE_CLK, RST, INTERNAL_PHY_SEL, MGMT_PORT_SELECT, TX_NIBBLE_VALID;
    logic        MII_COL, MII_CRS, MGMT_START_REQ, MGMT_READ, strap_level, refused;
    logic [3:0]  TX_NIBBLE;
    logic [4:0]  MGMT_PHY_ADDR, MGMT_REG_ADDR;
    logic [15:0] MGMT_WDATA;
    wire  [3:0]  RX_NIBBLE, MII_TXD, MII_RXD;
    wire  [15:0] MGMT_RDATA;
    wire         TX_NIBBLE_READY, RX_NIBBLE_VALID, RX_FRAME_ERR, COLLISION, CARRIER, MDC;
    wire         MII_TX_CLK, MII_TX_EN, MII_RX_CLK, MII_RX_DV, MII_RX_ER, MDIO_OUT, MDIO_OE;
    wire         OUTSIDE_PHY_STRAP, MGMT_BUSY, MGMT_DONE, mdio_pin, phy_drv, phy_bit;
    int          errors, comparisons;
    // pin rests at the strap or pull-down level when neither side drives
    assign mdio_pin = MDIO_OE ? MDIO_OUT : (phy_drv ? phy_bit : strap_level);
    mii_port i_mii_port (.CORE_CLK, .RST, .INTERNAL_PHY_SEL, .MGMT_PORT_SELECT, .TX_NIBBLE,
        .TX_NIBBLE_VALID, .TX_NIBBLE_READY, .RX_NIBBLE, .RX_NIBBLE_VALID, .RX_FRAME_ERR,
        .COLLISION, .CARRIER, .MII_TX_CLK, .MII_TXD, .MII_TX_EN, .MII_RX_CLK, .MII_RXD,
        .MII_RX_DV, .MII_RX_ER, .MII_COL, .MII_CRS, .MDC, .MDIO_IN(mdio_pin), .MDIO_OUT,
        .MDIO_OE, .OUTSIDE_PHY_STRAP, .MGMT_START_REQ, .MGMT_READ, .MGMT_PHY_ADDR,
        .MGMT_REG_ADDR, .MGMT_WDATA, .MGMT_RDATA, .MGMT_BUSY, .MGMT_DONE);
    phy_model i_phy_model (.tx_clk(MII_TX_CLK), .rx_clk(MII_RX_CLK), .txd(MII_TXD),
        .tx_en(MII_TX_EN), .rxd(MII_RXD), .rx_dv(MII_RX_DV), .rx_er(MII_RX_ER), .mdc(MDC),
        .mdio(mdio_pin), .mdio_drv(phy_drv), .mdio_bit(phy_bit));
    ////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge CORE_CLK);
    endtask
    task automatic do_reset(input logic s);
        @(negedge CORE_CLK);
        RST = 1'b1;
        strap_level = s;
        cyc(2);
        RST = 1'b0;
        cyc(25);
        check("strap", s, OUTSIDE_PHY_STRAP);
        strap_level = 1'b0;
        check("mdc idle", 0, MDC);
        check("mdio oe idle", 0, MDIO_OE);
    endtask
    task automatic push(input logic [3:0] n);
        int k;
        for (k = 0; TX_NIBBLE_READY !== 1'b1 && k < 200; k++) begin
            refused = 1'b1;
            cyc(1);
        end
        TX_NIBBLE = n;
        TX_NIBBLE_VALID = 1'b1;
        cyc(1);
        TX_NIBBLE_VALID = 1'b0;
        cyc(1);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_tx_fill;
        int i;
        refused = 1'b0;
        i_phy_model.tx_seen.delete();
        for (i = 0; i < 12; i++) push(4'(i + 3));
        cyc(250);
        check("fifo refused", 1, refused);
        check("tx count", 12, i_phy_model.tx_seen.size());
        for (i = 0; i < 12; i++) check("txd", i + 3, i_phy_model.tx_seen[i]);
        check("tx_en idle", 0, MII_TX_EN);
    endtask
    task automatic t_internal;
        int i;
        logic bad;
        bad = 1'b0;
        i_phy_model.tx_seen.delete();
        INTERNAL_PHY_SEL = 1'b1;
        cyc(20);
        push(4'h9);
        push(4'h6);
        for (i = 0; i < 60; i++) begin
            cyc(1);
            if (MII_TX_EN !== 1'b0 || MII_TXD !== 4'h0) bad = 1'b1;
        end
        check("parked", 0, bad);
        INTERNAL_PHY_SEL = 1'b0;
        cyc(60);
        check("tx after park", 2, i_phy_model.tx_seen.size());
    endtask
    task automatic t_rx;
        int i;
        logic err;
        logic [3:0] got[$];
        err = 1'b0;
        fork
            i_phy_model.send_frame(16'h5a3c, 4'b0100);
            for (i = 0; i < 90; i++) begin
                cyc(1);
                if (RX_NIBBLE_VALID === 1'b1) got.push_back(RX_NIBBLE);
                if (RX_FRAME_ERR === 1'b1) err = 1'b1;
            end
        join
        check("rx count", 4, got.size());
        for (i = 0; i < 4; i++) check("rx nibble", 16'h5a3c >> (12 - 4 * i) & 15, got[i]);
        check("rx err seen", 1, err);
        check("rx err cleared", 0, RX_FRAME_ERR);
        MII_COL = 1'b1;
        MII_CRS = 1'b1;
        cyc(10);
        check("collision", 1, COLLISION);
        check("carrier", 1, CARRIER);
        MII_COL = 1'b0;
        MII_CRS = 1'b0;
        cyc(10);
        check("collision off", 0, COLLISION);
        check("carrier off", 0, CARRIER);
    endtask
    task automatic t_mgmt;
        int k;
        MGMT_START_REQ = 1'b1;
        cyc(3);
        MGMT_START_REQ = 1'b0;
        check("start refused", 0, MGMT_BUSY);
        MGMT_PORT_SELECT = 1'b1;
        {MGMT_PHY_ADDR, MGMT_REG_ADDR, MGMT_WDATA} = {5'h0a, 5'h13, 16'ha5c3};
        cyc(2);
        MGMT_START_REQ = 1'b1;
        cyc(1);
        MGMT_START_REQ = 1'b0;
        for (k = 0; MGMT_DONE !== 1'b1 && k < 3000; k++) cyc(1);
        check("mgmt done", 1, MGMT_DONE);
        check("preamble", 32'hffff_ffff, i_phy_model.mdio_shift[63:32]);
        check("frame", {4'h5, 5'h0a, 5'h13, 2'h2, 16'ha5c3}, i_phy_model.mdio_shift[31:0]);
        MGMT_PORT_SELECT = 1'b0;
        cyc(3);
        check("mdc parked", 0, MDC);
    endtask
    task automatic t_mgmt_read;
        int k;
        MGMT_PORT_SELECT = 1'b1;
        MGMT_READ = 1'b1;
        {MGMT_PHY_ADDR, MGMT_REG_ADDR} = {5'h15, 5'h06};
        i_phy_model.rd_word = 16'h3c5a;
        i_phy_model.rises = 0;
        cyc(2);
        MGMT_START_REQ = 1'b1;
        cyc(1);
        MGMT_START_REQ = 1'b0;
        for (k = 0; MGMT_DONE !== 1'b1 && k < 3000; k++) cyc(1);
        check("rd done", 1, MGMT_DONE);
        check("rd header", {4'h6, 5'h15, 5'h06}, i_phy_model.mdio_shift[31:18]);
        check("rd turnaround", 0, i_phy_model.mdio_shift[17]);
        check("rd data", 16'h3c5a, MGMT_RDATA);
        MGMT_READ = 1'b0;
        MGMT_PORT_SELECT = 1'b0;
        cyc(3);
        check("mdio oe parked", 0, MDIO_OE);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // clock, watchdog and main sequence
    initial begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end
    initial begin
        #400000;
        errors++;
        tally_and_finish;
    end
    initial begin
        {RST, INTERNAL_PHY_SEL, MGMT_PORT_SELECT, TX_NIBBLE_VALID, MII_COL} = 5'h10;
        {MII_CRS, MGMT_START_REQ, MGMT_READ, strap_level, TX_NIBBLE} = 8'h00;
        {MGMT_PHY_ADDR, MGMT_REG_ADDR, MGMT_WDATA} = 26'h0;
        errors = 0;
        comparisons = 0;
        do_reset(1'b1);
        do_reset(1'b0);
        t_tx_fill;
        t_internal;
        t_rx;
        t_mgmt;
        t_mgmt_read;
        tally_and_finish;
    end
endmodule
